// ---- design/chan_ctl_consts.svh ----
// register offsets, field positions, reset values, mute delay, calibration length and unmapped read data for the channel control bank
`ifndef CHAN_CTL_CONSTS_SVH
`define CHAN_CTL_CONSTS_SVH
`define REG_PDC 14'h2100
`define REG_GRP 14'h2101
`define REG_DIVA 14'h2102
`define REG_DIVB 14'h2103
`define REG_DIVC 14'h2104
`define REG_LOOP 14'h2105
`define REG_FAST 14'h2106
`define REG_CLR 14'h2107
`define REG_STAT 14'h2108
`define REG_RESET 8'h00
`define PDC_MASK 8'h03
`define GRP_MASK 8'h0F
`define DIV_MASK 8'h3F
`define FAST_MASK 8'h0F
`define CLR_MASK 8'h1B
`define BIT_PWRDN 0
`define BIT_CAL 1
`define BIT_NSHOT 0
`define BIT_MUTE 1
`define BIT_RST 2
`define BIT_SYNC 3
`define DIV_RST_P 0
`define DIV_RST_N 1
`define DIV_MUTE_P 2
`define DIV_MUTE_N 3
`define DIV_PWRDN 4
`define DIV_DRV_RST 5
`define MUTE_DELAY 4'h3
`define CAL_CYCLES 8'h10
`define BAD_ADDR_DATA 32'h0000_0000
`endif

// ---- design/chan_ctl_pkg.sv ----
// types shared by the channel control bank
package chan_ctl_pkg;
    typedef struct packed {
        logic [13:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } av_req_t;
    typedef struct packed {
        logic [2:0] div_reset;
        logic [2:0] drv_mute;
        logic [2:0] drv_tristate;
    } drv_ctl_t;
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_ARMED = 2'b01,
        CAL_RUN = 2'b11
    } cal_state_t;
endpackage : chan_ctl_pkg

// ---- design/channel_operational_control.sv ----
// operational control register bank for the first output channel
// Contract
// R1: a calibrate bit rising zero to one arms a calibration run at the next update; code drops an arm pulse mid-run unless it hits the last run cycle.
// R2: software requests calibration at setup and whenever the vco frequency changes.
// R3: software requests calibration only after dividers are set and input is present.
// R4: the calibrate bit keeps its written value; software writes zero afterwards.
// R5: channel power-down powers down the channel and tristates every output.
// R6: sync holds all drivers static and their dividers in reset.
// R7: in sync, differential drivers stay muted.
// R8: clearing sync releases all outputs together in one cycle; code drops divider resets at the release pulse, mutes a cycle later.
// R9: software uses mute, not sync, to make drivers static without divider reset.
// R10: software uses driver power-down, not sync or mute, for high impedance.
// R11: all eight registers are eight bits and reset to zero.
// R12: group reset mutes at once, group mute mutes delayed; unmute is runt-free.
// R13: a calibration request is found by comparing new and held calibrate values.
`timescale 1ns/1ps
`include "chan_ctl_consts.svh"
module channel_operational_control (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [13:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    input wire logic io_update,
    output logic channel_power_down,
    output logic [2:0] div_reset_positive,
    output logic [2:0] div_reset_negative,
    output logic [2:0] drv_mute_positive,
    output logic [2:0] drv_mute_negative,
    output logic [2:0] drv_tristate,
    output logic outputs_release,
    output logic nshot_request,
    output logic [7:0] loop_mode,
    output logic [3:0] fast_acq_enable,
    output logic [4:0] clear_pulse,
    output logic vco_cal_busy
);
    chan_ctl_pkg::av_req_t req;
    logic [7:0] pdc_ff, grp_ff, diva_ff, divb_ff, divc_ff, loop_ff, fast_ff, clr_ff;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic [1:0] resp_ff;
    logic upd_meta_ff, upd_sync_ff, upd_last_ff;
    logic cal_arm_ff;
    logic cal_done_ff;
    logic sync_last_ff;
    logic release_ff;
    logic pwr_ff;
    logic [2:0] rstp_ff, rstn_ff, mutep_ff, muten_ff;
    logic [2:0] tri_ff;
    logic [4:0] clrp_ff;
    logic [2:0] sub_muted, sub_tri;
    logic cal_busy_w, cal_done_w;

    // writable bits of each register; zero marks an unmapped address or the read-only status register
    function automatic logic [7:0] sel_mask(input logic [13:0] a);
        case (a)
            `REG_PDC: sel_mask = `PDC_MASK;
            `REG_GRP: sel_mask = `GRP_MASK;
            `REG_DIVA, `REG_DIVB, `REG_DIVC: sel_mask = `DIV_MASK;
            `REG_LOOP: sel_mask = 8'hFF;
            `REG_FAST: sel_mask = `FAST_MASK;
            `REG_CLR: sel_mask = `CLR_MASK;
            default: sel_mask = 8'h00;
        endcase
    endfunction : sel_mask

    // request carrier and address decode
    assign req = '{address: address, read: read, write: write, writedata: writedata,
        byteenable: byteenable};
    wire req_go = (req.read || req.write) && !ack_ff;
    wire wr_go = req.write && ack_ff && req.byteenable[0]; // store at the completing edge
    wire mapped = (sel_mask(req.address) != 8'h00) || (req.address == `REG_STAT);
    wire [7:0] wmask = sel_mask(req.address);
    wire [7:0] wbyte = req.writedata[7:0] & wmask;
    wire wr_pdc = wr_go && (req.address == `REG_PDC);
    wire wr_grp = wr_go && (req.address == `REG_GRP);
    wire wr_clr = wr_go && (req.address == `REG_CLR);
    wire wr_diva = wr_go && (req.address == `REG_DIVA);
    wire wr_divb = wr_go && (req.address == `REG_DIVB);
    wire wr_divc = wr_go && (req.address == `REG_DIVC);
    wire wr_loop = wr_go && (req.address == `REG_LOOP);
    wire wr_fast = wr_go && (req.address == `REG_FAST);
    wire [7:0] stat_byte = {6'h00, cal_done_ff, cal_busy_w};
    wire upd_rise = upd_sync_ff && !upd_last_ff;

    // readback mux
    wire [7:0] rd_byte =
        (req.address == `REG_PDC) ? pdc_ff :
        (req.address == `REG_GRP) ? grp_ff :
        (req.address == `REG_DIVA) ? diva_ff :
        (req.address == `REG_DIVB) ? divb_ff :
        (req.address == `REG_DIVC) ? divc_ff :
        (req.address == `REG_LOOP) ? loop_ff :
        (req.address == `REG_FAST) ? fast_ff :
        (req.address == `REG_CLR) ? clr_ff :
        (req.address == `REG_STAT) ? stat_byte : 8'h00;

    // calibrate bit rising edge found against the held value
    wire cal_rise = wr_pdc && wbyte[`BIT_CAL] && !pdc_ff[`BIT_CAL]; // R13

    // bus answer: one wait cycle, then waitrequest low for one edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            rdata_ff <= `BAD_ADDR_DATA;
            resp_ff <= 2'b00;
        end else begin
            ack_ff <= req_go;
            rdata_ff <= req_go ? {24'h000000, rd_byte} : rdata_ff;
            resp_ff <= req_go ? (mapped ? 2'b00 : 2'b11) : resp_ff;
        end
    end

    // register storage, reset to zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pdc_ff <= `REG_RESET; // R11
            grp_ff <= `REG_RESET;
            diva_ff <= `REG_RESET;
            divb_ff <= `REG_RESET;
            divc_ff <= `REG_RESET;
            loop_ff <= `REG_RESET;
            fast_ff <= `REG_RESET;
            clr_ff <= `REG_RESET;
        end else begin
            pdc_ff <= wr_pdc ? wbyte : pdc_ff; // R4
            grp_ff <= wr_grp ? wbyte : grp_ff;
            diva_ff <= wr_diva ? wbyte : diva_ff;
            divb_ff <= wr_divb ? wbyte : divb_ff;
            divc_ff <= wr_divc ? wbyte : divc_ff;
            loop_ff <= wr_loop ? wbyte : loop_ff;
            fast_ff <= wr_fast ? wbyte : fast_ff;
            clr_ff <= wr_clr ? wbyte : clr_ff;
        end
    end

    // update input synchroniser and one-cycle calibration arm pulse register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            upd_meta_ff <= 1'b0;
            upd_sync_ff <= 1'b0;
            upd_last_ff <= 1'b0;
            cal_arm_ff <= 1'b0;
            cal_done_ff <= 1'b0;
        end else begin
            upd_meta_ff <= io_update;
            upd_sync_ff <= upd_meta_ff;
            upd_last_ff <= upd_sync_ff;
            cal_arm_ff <= cal_rise; // R1
            cal_done_ff <= cal_done_w || (cal_done_ff && !cal_rise);
        end
    end

    vco_cal_seq u_cal (
        .clock(clock),
        .rst_n(rst_n),
        .arm(cal_arm_ff),
        .io_update_sync(upd_rise),
        .cal_busy(cal_busy_w),
        .cal_done(cal_done_w)
    );

    // per-pair driver controls
    wire [7:0] div_regs [3] = '{diva_ff, divb_ff, divc_ff};
    wire pwr = pdc_ff[`BIT_PWRDN];
    wire sync_on = grp_ff[`BIT_SYNC];
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_pair
            driver_gate u_gate (
                .clock(clock),
                .rst_n(rst_n),
                .mute_req(grp_ff[`BIT_MUTE] || sync_on), // R7
                .hard_req(grp_ff[`BIT_RST] || div_regs[g][`DIV_DRV_RST]), // R12
                .tristate_req(pwr || div_regs[g][`DIV_PWRDN]), // R5
                .muted(sub_muted[g]),
                .tristated(sub_tri[g])
            );
        end
    endgenerate

    // output register stage: every pin comes from a flip-flop
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwr_ff <= 1'b0;
            rstp_ff <= 3'h0;
            rstn_ff <= 3'h0;
            mutep_ff <= 3'h0;
            muten_ff <= 3'h0;
            tri_ff <= 3'h0;
            sync_last_ff <= 1'b0;
            release_ff <= 1'b0;
            clrp_ff <= 5'h00;
        end else begin
            pwr_ff <= pwr; // R5
            rstp_ff <= {divc_ff[`DIV_RST_P], divb_ff[`DIV_RST_P], diva_ff[`DIV_RST_P]}
                | {3{sync_on}}; // R6
            rstn_ff <= {divc_ff[`DIV_RST_N], divb_ff[`DIV_RST_N], diva_ff[`DIV_RST_N]}
                | {3{sync_on}};
            mutep_ff <= sub_muted | {3{sync_on}} |
                {divc_ff[`DIV_MUTE_P], divb_ff[`DIV_MUTE_P], diva_ff[`DIV_MUTE_P]};
            muten_ff <= sub_muted | {3{sync_on}} |
                {divc_ff[`DIV_MUTE_N], divb_ff[`DIV_MUTE_N], diva_ff[`DIV_MUTE_N]};
            tri_ff <= sub_tri | {3{pwr}};
            sync_last_ff <= sync_on;
            release_ff <= sync_last_ff && !sync_on; // R8
            clrp_ff <= wr_clr ? wbyte[4:0] : 5'h00;
        end
    end

    assign readdata = rdata_ff;
    assign waitrequest = !ack_ff;
    assign response = resp_ff;
    assign channel_power_down = pwr_ff;
    assign div_reset_positive = rstp_ff;
    assign div_reset_negative = rstn_ff;
    assign drv_mute_positive = mutep_ff;
    assign drv_mute_negative = muten_ff;
    assign drv_tristate = tri_ff;
    assign outputs_release = release_ff;
    assign nshot_request = grp_ff[`BIT_NSHOT];
    assign loop_mode = loop_ff;
    assign fast_acq_enable = fast_ff[3:0];
    assign clear_pulse = clrp_ff;
    assign vco_cal_busy = cal_busy_w;

    // two-cycle holds and a single-cycle calibrate rise, used by the checks below
    sequence s_group_reset_held;
        grp_ff[`BIT_RST] ##1 grp_ff[`BIT_RST];
    endsequence
    sequence s_pair_power_held;
        diva_ff[`DIV_PWRDN] ##1 diva_ff[`DIV_PWRDN];
    endsequence
    sequence s_cal_rise_write;
        wr_pdc && wbyte[`BIT_CAL] && !pdc_ff[`BIT_CAL];
    endsequence

    // calibration request and register contents
    a_cal_edge_only: assert property (@(posedge clock) disable iff (!rst_n) // R1
        (wr_pdc && pdc_ff[`BIT_CAL]) |=> !cal_arm_ff)
        else $error("calibration armed without a rising bit");
    a_cal_rise_arms: assert property (@(posedge clock) disable iff (!rst_n) // R1 R13
        s_cal_rise_write |=> cal_arm_ff && pdc_ff[`BIT_CAL])
        else $error("calibrate rising write did not arm");
    a_cal_not_self: assert property (@(posedge clock) disable iff (!rst_n) // R4
        (pdc_ff[`BIT_CAL] && !wr_pdc) |=> pdc_ff[`BIT_CAL])
        else $error("calibrate bit cleared itself");
    a_cal_write_kept: assert property (@(posedge clock) disable iff (!rst_n) // R4
        wr_pdc |=> pdc_ff == $past(wbyte))
        else $error("calibrate register lost its written value");
    a_done_sticky: assert property (@(posedge clock) disable iff (!rst_n)
        (cal_done_ff && !cal_rise) |=> cal_done_ff)
        else $error("calibration done flag dropped early");
    a_reg_reset: assert property (@(posedge clock) // R11
        !rst_n |-> (pdc_ff == `REG_RESET) && (grp_ff == `REG_RESET))
        else $error("register not zero under reset");
    a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_n) // R11
        ((pdc_ff & ~`PDC_MASK) == 8'h00) && ((grp_ff & ~`GRP_MASK) == 8'h00))
        else $error("reserved bit set in a control register");

    // power-down, sync and mute at the pins
    a_pwr_tristate: assert property (@(posedge clock) disable iff (!rst_n) // R5
        pwr |=> (drv_tristate == 3'h7) && channel_power_down)
        else $error("power-down did not tristate outputs");
    a_pair_power_pin: assert property (@(posedge clock) disable iff (!rst_n)
        s_pair_power_held |=> drv_tristate[0])
        else $error("pair power-down did not tristate its driver");
    a_div_reset_pair: assert property (@(posedge clock) disable iff (!rst_n)
        diva_ff[`DIV_RST_P] |=> div_reset_positive[0])
        else $error("pair divider reset did not reach its pin");
    a_sync_holds: assert property (@(posedge clock) disable iff (!rst_n) // R6
        sync_on |=> (div_reset_positive == 3'h7) && (div_reset_negative == 3'h7))
        else $error("sync did not hold dividers in reset");
    a_sync_muted: assert property (@(posedge clock) disable iff (!rst_n) // R7
        sync_on |=> (drv_mute_positive == 3'h7) && (drv_mute_negative == 3'h7))
        else $error("sync left a driver unmuted");
    a_hard_mute_pins: assert property (@(posedge clock) disable iff (!rst_n) // R12
        s_group_reset_held |=> (drv_mute_positive == 3'h7) && (drv_mute_negative == 3'h7))
        else $error("group reset did not mute every driver pin");

    // release pulse, one-shot clears and bus answer
    a_sync_release: assert property (@(posedge clock) disable iff (!rst_n) // R8
        $fell(sync_on) |=> outputs_release ##1 !outputs_release)
        else $error("release pulse missing on sync clear");
    a_release_after_clear: assert property (@(posedge clock) disable iff (!rst_n) // R8
        $rose(outputs_release) |-> $past(sync_on, 2) && !$past(sync_on))
        else $error("release pulse without a sync clear");
    a_clear_one_shot: assert property (@(posedge clock) disable iff (!rst_n)
        !wr_clr |=> clear_pulse == 5'h00)
        else $error("clear pulse without a clear write");
    a_bus_answer: assert property (@(posedge clock) disable iff (!rst_n)
        (req_go) |=> !waitrequest)
        else $error("bus request not answered in one cycle");
    a_ack_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
        !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_unmapped_refused: assert property (@(posedge clock) disable iff (!rst_n)
        (req_go && !mapped) |=> (response == 2'b11) && (readdata == 32'h0000_0000))
        else $error("unmapped access not refused");
endmodule : channel_operational_control

// ---- design/driver_gate.sv ----
// one driver pair: delayed runt-free mute, immediate reset mute, tristate
`timescale 1ns/1ps
`include "chan_ctl_consts.svh"
module driver_gate (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic mute_req,
    input wire logic hard_req,
    input wire logic tristate_req,
    output logic muted,
    output logic tristated
);
    logic [3:0] dly_ff;
    logic muted_ff;
    logic tri_ff;
    wire dly_done = (dly_ff == `MUTE_DELAY);

    // mute after a delay so the running cycle completes; hard reset mutes at once
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dly_ff <= 4'h0;
            muted_ff <= 1'b0;
            tri_ff <= 1'b0;
        end else begin
            dly_ff <= (mute_req && !dly_done) ? dly_ff + 4'h1 : (mute_req ? dly_ff : 4'h0);
            muted_ff <= hard_req || (mute_req && dly_done); // R12
            tri_ff <= tristate_req;
        end
    end

    assign muted = muted_ff;
    assign tristated = tri_ff;

    a_hard_mute_fast: assert property (@(posedge clock) disable iff (!rst_n) // R12
        hard_req |=> muted)
        else $error("reset did not mute at once");
    a_soft_mute_slow: assert property (@(posedge clock) disable iff (!rst_n) // R12
        $rose(mute_req) && !hard_req && !muted ##1 !hard_req |-> !muted)
        else $error("mute applied without delay");
endmodule : driver_gate

// ---- design/vco_cal_seq.sv ----
// analog loop vco calibration sequencer, armed by a request and run on update
`timescale 1ns/1ps
`include "chan_ctl_consts.svh"
module vco_cal_seq (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic arm,
    input wire logic io_update_sync,
    output logic cal_busy,
    output logic cal_done
);
    chan_ctl_pkg::cal_state_t state_ff;
    chan_ctl_pkg::cal_state_t nxt_state;
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic busy_ff;
    logic done_ff;
    wire run_end = (state_ff == chan_ctl_pkg::CAL_RUN) && (cnt_ff == 8'h01);

    // arm waits for the next update, then runs a fixed-length calibration
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            chan_ctl_pkg::CAL_IDLE: begin
                if (arm) begin
                    nxt_state = chan_ctl_pkg::CAL_ARMED;
                end
            end
            chan_ctl_pkg::CAL_ARMED: begin
                if (io_update_sync) begin
                    nxt_state = chan_ctl_pkg::CAL_RUN; // R1
                    nxt_cnt = `CAL_CYCLES;
                end
            end
            chan_ctl_pkg::CAL_RUN: begin
                nxt_cnt = cnt_ff - 8'h01;
                if (run_end) begin
                    nxt_state = arm ? chan_ctl_pkg::CAL_ARMED : chan_ctl_pkg::CAL_IDLE;
                end
            end
            default: begin
                nxt_state = chan_ctl_pkg::CAL_IDLE;
            end
        endcase
    end

    // state, counter and registered flags
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= chan_ctl_pkg::CAL_IDLE;
            cnt_ff <= 8'h00;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            busy_ff <= (nxt_state == chan_ctl_pkg::CAL_RUN);
            done_ff <= run_end;
        end
    end

    assign cal_busy = busy_ff;
    assign cal_done = done_ff;

    a_cal_waits_update: assert property (@(posedge clock) disable iff (!rst_n) // R1
        (state_ff == chan_ctl_pkg::CAL_ARMED && !io_update_sync)
        |=> state_ff != chan_ctl_pkg::CAL_RUN)
        else $error("calibration started without an update");
endmodule : vco_cal_seq

// ---- tb/channel_operational_control_bench.sv ----
// self-checking bench for the channel operational control register bank
`timescale 1ns/1ps
`include "chan_ctl_consts.svh"
module channel_operational_control_bench;
    logic clock, rst_n, read, write, io_update;
    logic [13:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [3:0] byteenable;
    logic waitrequest, channel_power_down, outputs_release, nshot_request, vco_cal_busy;
    logic [1:0] response, rs;
    logic [2:0] div_reset_positive, div_reset_negative, drv_mute_positive;
    logic [2:0] drv_mute_negative, drv_tristate;
    logic [7:0] loop_mode;
    logic [3:0] fast_acq_enable;
    logic [4:0] clear_pulse, clr_seen;
    logic [5:0] rel_div;
    logic [7:0] shadow [8];
    int errors, compares, rel_cnt, clr_cnt;
    wire [28:0] seen_outs = {channel_power_down, div_reset_positive, div_reset_negative,
        drv_mute_positive, drv_mute_negative, drv_tristate, nshot_request, loop_mode,
        fast_acq_enable};

    channel_operational_control i_channel_operational_control (
        .clock, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .response, .io_update, .channel_power_down, .div_reset_positive,
        .div_reset_negative, .drv_mute_positive, .drv_mute_negative, .drv_tristate,
        .outputs_release, .nshot_request, .loop_mode, .fast_acq_enable, .clear_pulse,
        .vco_cal_busy
    );

    // clock generation
    initial clock = 1'b0;
    always #25 clock = ~clock;

    // monitors of one-cycle pulses, sampled before the edge updates land
    always @(posedge clock) begin
        if (outputs_release === 1'b1) begin
            rel_cnt++;
            rel_div = {div_reset_positive, div_reset_negative};
        end
        if (clear_pulse !== 5'h00) begin
            clr_cnt++;
            clr_seen = clr_seen | clear_pulse;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task results;
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // writable bits of registers 0 to 6; the clear register 7 gets none
    function automatic logic [7:0] mask(input int r);
        case (r)
            0: return 8'h03;
            1, 6: return 8'h0F;
            2, 3, 4: return 8'h3F;
            5: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction : mask

    // settled outputs expected from the register contents
    function automatic logic [28:0] model();
        logic [7:0] g;
        logic [2:0] rp, rn, mp, mn, ts;
        g = shadow[1];
        for (int i = 0; i < 3; i++) begin
            rp[i] = shadow[i + 2][0] | g[3];
            rn[i] = shadow[i + 2][1] | g[3];
            mp[i] = |{g[3:1], shadow[i + 2][5], shadow[i + 2][2]};
            mn[i] = |{g[3:1], shadow[i + 2][5], shadow[i + 2][3]};
            ts[i] = shadow[0][0] | shadow[i + 2][4];
        end
        return {shadow[0][0], rp, rn, mp, mn, ts, g[0], shadow[5], shadow[6][3:0]};
    endfunction : model

    // one avalon transfer, held until a rising edge samples waitrequest low
    task automatic bus(input logic w, input int r, input logic [7:0] d, input logic [3:0] be);
        @(posedge clock);
        address <= 14'h2100 + r[13:0];
        write <= w;
        read <= !w;
        writedata <= {24'($urandom), d};
        byteenable <= be;
        do begin
            @(posedge clock);
        end while (waitrequest !== 1'b0);
        check({31'h0, waitrequest}, 32'h0);
        rd = readdata;
        rs = response;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus

    task automatic wr(input int r, input logic [7:0] d);
        bus(1'b1, r, d, 4'hF);
        if (r < 8) shadow[r] = d & mask(r);
    endtask : wr

    task automatic rdchk(input int r, input logic [7:0] e);
        bus(1'b0, r, 8'h00, 4'hF);
        check(rd, {24'h0, e});
        check({30'h0, rs}, 32'h0);
    endtask : rdchk

    task do_reset;
        rst_n <= 1'b0;
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        foreach (shadow[i]) shadow[i] = 8'h00;
    endtask : do_reset

    // update pulse of four cycles, then count calibration busy cycles
    task automatic cal_run(output int c);
        c = 0;
        for (int i = 0; i < 60; i++) begin
            @(posedge clock);
            io_update <= (i < 4);
            if (vco_cal_busy === 1'b1) c++;
        end
    endtask : cal_run

    // time from a group control write until all positive drivers are muted
    task automatic mute_time(input logic [7:0] d, output int c);
        wr(1, d);
        c = 0;
        while (drv_mute_positive !== 3'h7 && c < 20) begin
            @(posedge clock);
            c++;
        end
        wr(1, 8'h00);
        repeat (10) @(posedge clock);
        check({3'h0, seen_outs}, {3'h0, model()});
    endtask : mute_time

    // watchdog
    initial begin
        #(50 * 20000);
        errors++;
        results();
    end

    // main sequence
    initial begin
        logic [7:0] d;
        int r, c, cm;
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 14'h0000;
        writedata = 32'h0;
        byteenable = 4'h0;
        io_update = 1'b0;
        errors = 0;
        compares = 0;
        rel_cnt = 0;
        clr_cnt = 0;
        clr_seen = 5'h00;
        rel_div = 6'h00;
        d = 8'($urandom(32'h0E2E7ED9));
        do_reset();
        for (r = 0; r < 8; r++) rdchk(r, 8'h00);
        check({3'h0, seen_outs}, 32'h0);
        wr(9, 8'hFF);
        bus(1'b0, 9, 8'h00, 4'hF);
        check(rd, 32'h0);
        check({30'h0, rs}, 32'h3);
        bus(1'b1, 5, 8'hA5, 4'hE);
        rdchk(5, 8'h00);
        $display("test reset and refusal done");
        for (int k = 0; k < 40; k++) begin
            r = $urandom_range(6);
            d = (k % 10 == 0) ? 8'hFF : 8'($urandom);
            wr(r, d);
            repeat (8) @(posedge clock);
            check({3'h0, seen_outs}, {3'h0, model()});
            r = $urandom_range(6);
            rdchk(r, shadow[r]);
        end
        $display("test random access done");
        do_reset();
        for (r = 0; r < 8; r++) rdchk(r, 8'h00);
        wr(1, 8'h08);
        repeat (8) @(posedge clock);
        check({3'h0, seen_outs}, {3'h0, model()});
        rel_cnt = 0;
        wr(1, 8'h00);
        repeat (6) @(posedge clock);
        check(32'(rel_cnt), 32'h1);
        check({26'h0, rel_div}, 32'h0);
        $display("test sync release done");
        mute_time(8'h04, c);
        mute_time(8'h02, cm);
        check({31'h0, c < cm}, 32'h1);
        check({31'h0, cm < 20}, 32'h1);
        wr(2, 8'h10);
        repeat (8) @(posedge clock);
        check({3'h0, seen_outs}, {3'h0, model()});
        $display("test group mute done");
        wr(0, 8'h02);
        repeat (6) @(posedge clock);
        check({31'h0, vco_cal_busy}, 32'h0);
        cal_run(c);
        check(32'(c), 32'(`CAL_CYCLES));
        rdchk(0, 8'h02);
        rdchk(8, 8'h02);
        wr(0, 8'h02);
        cal_run(c);
        check(32'(c), 32'h0);
        wr(0, 8'h00);
        wr(0, 8'h02);
        cal_run(c);
        check(32'(c), 32'(`CAL_CYCLES));
        $display("test calibration done");
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom) | 8'h01;
            clr_cnt = 0;
            clr_seen = 5'h00;
            wr(7, d);
            repeat (4) @(posedge clock);
            check(32'(clr_cnt), 32'h1);
            check({27'h0, clr_seen}, {27'h0, d[4:0] & 5'h1B});
        end
        $display("test clear pulses done");
        results();
    end
endmodule : channel_operational_control_bench
